/* File: src/plm_lower_pin_mux.sv */
// How it works
// - bit 14: pin 7 gpio or serial ch2 clock
// - bit 12: pin 6 gpio or conversion end
// - bit 10: pin 5 gpio or trigger 1
// - bit 8: pin 4 gpio or trigger 0
// - bit 6: pin 3 gpio or timer clock b
// - bits 5:4: pin 2 gpio/cc11b/ext_interrupt_7/reserved
// - bits 3:2: pin 1 gpio/cc11a/ext_interrupt_6/reserved
// - bit 0: pin 0 gpio or edge input 10
// - reserved select bits read zero, write zero
// - invert bits 9..7 invert serial clock pins
// - inversion only while pin is serial clock
// - invert register clears on power-on reset only
// - only invert bits 9, 8, 7 writable
// - select register clears on power-on reset only
// - direction bit sets output for gpio/timer/clock
`timescale 1ns/100ps
module plm_lower_pin_mux
	import plm_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_ce,
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	input  wire logic [9:0]  i_pin_in,
	output logic      [7:0]  o_pin_out,
	output logic      [7:0]  o_pin_oe,
	output logic      [1:0]  o_pin_hi_out,
	input  wire logic        i_pin8_sck_sel,
	input  wire logic        i_pin9_sck_sel,
	input  wire logic [7:0]  i_gpio_out,
	output logic      [7:0]  o_gpio_in,
	input  wire logic        i_serial_ch2_clock_out,
	input  wire logic        i_serial_ch3_clock_out,
	input  wire logic        i_serial_ch4_clock_out,
	output logic             o_serial_ch2_clock_in,
	output logic             o_serial_ch3_clock_in,
	output logic             o_serial_ch4_clock_in,
	input  wire logic        i_conversion_end_out,
	output logic             o_conversion_trigger_1,
	output logic             o_conversion_trigger_0,
	output logic             o_timer_ext_clock_b,
	input  wire logic        i_timer_cc_ch11_b_out,
	input  wire logic        i_timer_cc_ch11_a_out,
	output logic             o_timer_cc_ch11_b_in,
	output logic             o_timer_cc_ch11_a_in,
	output logic             o_ext_interrupt_7_n,
	output logic             o_ext_interrupt_6_n,
	output logic             o_timer_edge_input_10
);
	typedef struct packed {
		logic [15:0] fsel;
		logic [15:0] inv;
		logic [7:0]  dir;
		logic        ack;
		logic [31:0] rdata;
		logic [7:0]  pout;
		logic [7:0]  poe;
		logic [1:0]  hout;
		logic [7:0]  gin;
		logic        serial_ch2_clock_in;
		logic        serial_ch3_clock_in;
		logic        serial_ch4_clock_in;
		logic        trig1;
		logic        trig0;
		logic        timer_ext_clock_b;
		logic        cc11b_in;
		logic        cc11a_in;
		logic        ext_interrupt_7_n;
		logic        ext_interrupt_6_n;
		logic        timer_edge_input_10;
	} plm_state_t;

	plm_state_t r_reg;
	plm_state_t r_next;

	plm_sync_if #(.W(PLM_SYNC_W)) pins_if ();

	plm_pin_sync #(
		.W (PLM_SYNC_W)
	) u_sync (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_ce     (i_ce),
		.io_pins  (pins_if.sync_side)
	);

	assign pins_if.raw = i_pin_in;

	logic [9:0]  pin_s;
	logic [7:0]  word_adr;
	logic        req;
	logic        wr_commit;
	plm_fn2_t    fn2;
	plm_fn2_t    fn1;
	logic        sel7;

	assign pin_s     = pins_if.sync;
	assign word_adr  = {i_wb_adr[7:2], 2'b00};
	assign req       = i_wb_cyc && i_wb_stb;
	// write lands at the edge where the master sees ack
	assign wr_commit = req && i_wb_we && r_reg.ack;
	assign fn2       = plm_fn2_t'(r_reg.fsel[PLM_P2_LO+1:PLM_P2_LO]);
	assign fn1       = plm_fn2_t'(r_reg.fsel[PLM_P1_LO+1:PLM_P1_LO]);
	assign sel7      = r_reg.fsel[PLM_P7_BIT];

	always_comb
	begin
		r_next = r_reg;

		// registered ack: one wait state, dropped the cycle after
		r_next.ack = req && !r_reg.ack;
		if (req && !r_reg.ack && !i_wb_we)
		begin
			case (word_adr)
				PLM_ADR_FSEL: r_next.rdata = {16'h0000, r_reg.fsel & PLM_FSEL_MASK};
				PLM_ADR_INV:  r_next.rdata = {16'h0000, r_reg.inv & PLM_INV_MASK};
				PLM_ADR_DIR:  r_next.rdata = {24'h000000, r_reg.dir};
				PLM_ADR_PIN:  r_next.rdata = {22'h000000, pin_s};
				default:      r_next.rdata = 32'h00000000;
			endcase
		end

		if (wr_commit)
		begin
			case (word_adr)
				PLM_ADR_FSEL:
				begin
					if (i_wb_sel[0])
						r_next.fsel[7:0] = i_wb_dat[7:0] & PLM_FSEL_MASK[7:0];
					if (i_wb_sel[1])
						r_next.fsel[15:8] = i_wb_dat[15:8] & PLM_FSEL_MASK[15:8];
				end
				PLM_ADR_INV:
				begin
					if (i_wb_sel[0])
						r_next.inv[7:0] = i_wb_dat[7:0] & PLM_INV_MASK[7:0];
					if (i_wb_sel[1])
						r_next.inv[15:8] = i_wb_dat[15:8] & PLM_INV_MASK[15:8];
				end
				PLM_ADR_DIR:
				begin
					if (i_wb_sel[0])
						r_next.dir = i_wb_dat[7:0];
				end
				default:
				begin
					r_next.dir = r_reg.dir;
				end
			endcase
		end

		// pin 7: gpio or serial ch2 clock, direction from dir bit
		r_next.poe[7] = r_reg.dir[7];
		if (sel7)
			r_next.pout[7] = i_serial_ch2_clock_out ^ r_reg.inv[PLM_INV7_BIT];
		else
			r_next.pout[7] = i_gpio_out[7];

		// pin 6: conversion end always drives
		if (r_reg.fsel[PLM_P6_BIT])
		begin
			r_next.pout[6] = i_conversion_end_out;
			r_next.poe[6]  = 1'b1;
		end
		else
		begin
			r_next.pout[6] = i_gpio_out[6];
			r_next.poe[6]  = r_reg.dir[6];
		end

		// pins 5, 4, 3, 0: peripheral inputs, pin never driven while its function is selected
		r_next.pout[5] = i_gpio_out[5];
		r_next.poe[5]  = r_reg.dir[5] && !r_reg.fsel[PLM_P5_BIT];
		r_next.pout[4] = i_gpio_out[4];
		r_next.poe[4]  = r_reg.dir[4] && !r_reg.fsel[PLM_P4_BIT];
		r_next.pout[3] = i_gpio_out[3];
		r_next.poe[3]  = r_reg.dir[3] && !r_reg.fsel[PLM_P3_BIT];
		r_next.pout[0] = i_gpio_out[0];
		r_next.poe[0]  = r_reg.dir[0] && !r_reg.fsel[PLM_P0_BIT];

		// pin 2; reserved code leaves the pin undriven as a safe fallback
		case (fn2)
			PLM_F2_GPIO:
			begin
				r_next.pout[2] = i_gpio_out[2];
				r_next.poe[2]  = r_reg.dir[2];
			end
			PLM_F2_TIMER:
			begin
				r_next.pout[2] = i_timer_cc_ch11_b_out;
				r_next.poe[2]  = r_reg.dir[2];
			end
			default:
			begin
				r_next.pout[2] = 1'b0;
				r_next.poe[2]  = 1'b0;
			end
		endcase

		// pin 1, same scheme as pin 2
		case (fn1)
			PLM_F2_GPIO:
			begin
				r_next.pout[1] = i_gpio_out[1];
				r_next.poe[1]  = r_reg.dir[1];
			end
			PLM_F2_TIMER:
			begin
				r_next.pout[1] = i_timer_cc_ch11_a_out;
				r_next.poe[1]  = r_reg.dir[1];
			end
			default:
			begin
				r_next.pout[1] = 1'b0;
				r_next.poe[1]  = 1'b0;
			end
		endcase

		// pins 8, 9: upper selector owns direction, only inversion here
		r_next.hout[0] = i_serial_ch3_clock_out
			^ (i_pin8_sck_sel && r_reg.inv[PLM_INV8_BIT]);
		r_next.hout[1] = i_serial_ch4_clock_out
			^ (i_pin9_sck_sel && r_reg.inv[PLM_INV9_BIT]);

		// peripheral inputs, parked inactive when unselected
		r_next.gin      = pin_s[7:0];
		r_next.serial_ch2_clock_in  = sel7 && (pin_s[7] ^ r_reg.inv[PLM_INV7_BIT]);
		r_next.serial_ch3_clock_in  = i_pin8_sck_sel && (pin_s[8] ^ r_reg.inv[PLM_INV8_BIT]);
		r_next.serial_ch4_clock_in  = i_pin9_sck_sel && (pin_s[9] ^ r_reg.inv[PLM_INV9_BIT]);
		r_next.trig1    = r_reg.fsel[PLM_P5_BIT] && pin_s[5];
		r_next.trig0    = r_reg.fsel[PLM_P4_BIT] && pin_s[4];
		r_next.timer_ext_clock_b    = r_reg.fsel[PLM_P3_BIT] && pin_s[3];
		r_next.cc11b_in = (fn2 == PLM_F2_TIMER) && pin_s[2];
		r_next.cc11a_in = (fn1 == PLM_F2_TIMER) && pin_s[1];
		r_next.ext_interrupt_7_n   = (fn2 == PLM_F2_IRQ) ? pin_s[2] : 1'b1;
		r_next.ext_interrupt_6_n   = (fn1 == PLM_F2_IRQ) ? pin_s[1] : 1'b1;
		r_next.timer_edge_input_10     = r_reg.fsel[PLM_P0_BIT] && pin_s[0];
	end

	// async reset stands for power-on and hardware standby; no other reset reaches here
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			r_reg        <= '0;
			r_reg.fsel   <= PLM_FSEL_RST;
			r_reg.inv    <= PLM_INV_RST;
			r_reg.dir    <= PLM_DIR_RST;
			r_reg.ext_interrupt_7_n <= 1'b1;
			r_reg.ext_interrupt_6_n <= 1'b1;
		end
		else if (i_ce)
			r_reg <= r_next;
	end

	// every pin-facing output comes from a flop, so a select change cannot glitch
	assign o_wb_dat               = r_reg.rdata;
	// gated by ce so the master never takes an ack on a frozen edge, where no write lands
	assign o_wb_ack               = r_reg.ack && i_ce;
	assign o_pin_out              = r_reg.pout;
	assign o_pin_oe               = r_reg.poe;
	assign o_pin_hi_out           = r_reg.hout;
	assign o_gpio_in              = r_reg.gin;
	assign o_serial_ch2_clock_in  = r_reg.serial_ch2_clock_in;
	assign o_serial_ch3_clock_in  = r_reg.serial_ch3_clock_in;
	assign o_serial_ch4_clock_in  = r_reg.serial_ch4_clock_in;
	assign o_conversion_trigger_1 = r_reg.trig1;
	assign o_conversion_trigger_0 = r_reg.trig0;
	assign o_timer_ext_clock_b    = r_reg.timer_ext_clock_b;
	assign o_timer_cc_ch11_b_in   = r_reg.cc11b_in;
	assign o_timer_cc_ch11_a_in   = r_reg.cc11a_in;
	assign o_ext_interrupt_7_n    = r_reg.ext_interrupt_7_n;
	assign o_ext_interrupt_6_n    = r_reg.ext_interrupt_6_n;
	assign o_timer_edge_input_10  = r_reg.timer_edge_input_10;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_arst_n);

	sequence s_fsel_wr;
		i_ce && wr_commit && (word_adr == PLM_ADR_FSEL) && (i_wb_sel[1:0] == 2'b11);
	endsequence

	sequence s_inv_wr;
		i_ce && wr_commit && (word_adr == PLM_ADR_INV) && (i_wb_sel[1:0] == 2'b11);
	endsequence

	sequence s_fsel_rd;
		i_ce && req && !i_wb_we && !r_reg.ack && (word_adr == PLM_ADR_FSEL);
	endsequence

	chk_pin7_clock_out: assert property (
		(i_ce && sel7) |=> (o_pin_out[7] == $past(i_serial_ch2_clock_out ^ r_reg.inv[7])))
		else $error("pin 7 not driven by serial clock");

	chk_pin6_conv_end: assert property (
		(i_ce && r_reg.fsel[PLM_P6_BIT])
		|=> (o_pin_oe[6] && (o_pin_out[6] == $past(i_conversion_end_out))))
		else $error("pin 6 not driving conversion end");

	chk_trig1_follow: assert property (
		(i_ce && r_reg.fsel[PLM_P5_BIT]) |=> (o_conversion_trigger_1 == $past(pin_s[5])))
		else $error("trigger 1 does not follow pin 5");

	chk_trig0_parked: assert property (
		(i_ce && !r_reg.fsel[PLM_P4_BIT]) |=> !o_conversion_trigger_0)
		else $error("trigger 0 active while unselected");

	chk_timer_ext_clock_b_follow: assert property (
		(i_ce && r_reg.fsel[PLM_P3_BIT]) |=> (o_timer_ext_clock_b == $past(pin_s[3])))
		else $error("timer clock b does not follow pin 3");

	chk_pin2_irq_mode: assert property (
		(i_ce && (fn2 == PLM_F2_IRQ))
		|=> (!o_pin_oe[2] && (o_ext_interrupt_7_n == $past(pin_s[2]))))
		else $error("pin 2 irq mode wrong");

	chk_pin1_timer_dir: assert property (
		(i_ce && (fn1 == PLM_F2_TIMER))
		|=> ((o_pin_oe[1] == $past(r_reg.dir[1])) && (o_pin_out[1] == $past(i_timer_cc_ch11_a_out))))
		else $error("pin 1 timer mode wrong");

	chk_timer_edge_input_10_parked: assert property (
		(i_ce && !r_reg.fsel[PLM_P0_BIT]) |=> !o_timer_edge_input_10)
		else $error("edge input 10 active while unselected");

	chk_fsel_rsvd_zero: assert property (
		s_fsel_rd |=> (r_reg.ack && ((o_wb_dat & ~{16'h0000, PLM_FSEL_MASK}) == 32'h00000000)))
		else $error("reserved select bits read nonzero");

	chk_fsel_write: assert property (
		s_fsel_wr |=> (r_reg.fsel == $past(i_wb_dat[15:0] & PLM_FSEL_MASK)))
		else $error("select register write lost");

	chk_inv_write: assert property (
		s_inv_wr |=> (r_reg.inv == $past(i_wb_dat[15:0] & PLM_INV_MASK)))
		else $error("invert register write wrong");

	chk_inv_gated: assert property (
		(i_ce && !i_pin9_sck_sel) |=> (!o_serial_ch4_clock_in
			&& (o_pin_hi_out[1] == $past(i_serial_ch4_clock_out))))
		else $error("inversion applied to unselected pin 9");

	chk_ack_pulse: assert property (
		(i_ce && o_wb_ack) |=> !o_wb_ack)
		else $error("ack held longer than one cycle");

	chk_dir_gpio: assert property (
		(i_ce && (fn2 == PLM_F2_GPIO)) |=> (o_pin_oe[2] == $past(r_reg.dir[2])))
		else $error("pin 2 direction not from dir bit");
endmodule

/* File: src/plm_pin_sync.sv */
`timescale 1ns/100ps
module plm_pin_sync
	import plm_pkg::*;
#(
	parameter int W = 10
)(
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	input  wire logic       i_ce,
	plm_sync_if.sync_side   io_pins
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} plm_sync_state_t;

	plm_sync_state_t r_reg;
	plm_sync_state_t r_next;

	// first stage feeds only the second stage
	always_comb
	begin
		r_next    = r_reg;
		r_next.s1 = io_pins.raw;
		r_next.s2 = r_reg.s1;
	end

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			r_reg <= '0;
		else if (i_ce)
			r_reg <= r_next;
	end

	assign io_pins.sync = r_reg.s2;
endmodule

/* File: src/plm_pkg.sv */
package plm_pkg;

	// register byte offsets on the wishbone bus
	localparam logic [7:0]  PLM_ADR_FSEL    = 8'h00;
	localparam logic [7:0]  PLM_ADR_INV     = 8'h04;
	localparam logic [7:0]  PLM_ADR_DIR     = 8'h08;
	localparam logic [7:0]  PLM_ADR_PIN     = 8'h0c;

	// reset values
	localparam logic [15:0] PLM_FSEL_RST    = 16'h0000;
	localparam logic [15:0] PLM_INV_RST     = 16'h0000;
	localparam logic [7:0]  PLM_DIR_RST     = 8'h00;

	// writable bits, everything else reads as zero
	localparam logic [15:0] PLM_FSEL_MASK   = 16'h557d;
	localparam logic [15:0] PLM_INV_MASK    = 16'h0380;

	// function-select field positions
	localparam int          PLM_P7_BIT      = 14;
	localparam int          PLM_P6_BIT      = 12;
	localparam int          PLM_P5_BIT      = 10;
	localparam int          PLM_P4_BIT      = 8;
	localparam int          PLM_P3_BIT      = 6;
	localparam int          PLM_P2_LO       = 4;
	localparam int          PLM_P1_LO       = 2;
	localparam int          PLM_P0_BIT      = 0;

	// invert bit positions
	localparam int          PLM_INV7_BIT    = 7;
	localparam int          PLM_INV8_BIT    = 8;
	localparam int          PLM_INV9_BIT    = 9;

	// number of synchronised pins (lower eight plus pins 8 and 9)
	localparam int          PLM_SYNC_W      = 10;

	typedef enum logic [1:0] {
		PLM_F2_GPIO  = 2'h0,
		PLM_F2_TIMER = 2'h1,
		PLM_F2_IRQ   = 2'h2,
		PLM_F2_RSVD  = 2'h3
	} plm_fn2_t;

endpackage

/* File: src/plm_sync_if.sv */
`timescale 1ns/100ps
interface plm_sync_if #(
	parameter int W = 10
);
	logic [W-1:0] raw;
	logic [W-1:0] sync;

	modport sync_side (input raw, output sync);
	modport user_side (output raw, input sync);
endinterface

/* File: test/plm_far_model.sv */
`timescale 1ns/100ps
module plm_far_model
(
	input  wire logic [7:0] i_pin_out,
	input  wire logic [7:0] i_pin_oe,
	input  wire logic [9:0] i_ext,
	output logic      [9:0] o_pin_in
);
	// undriven pins show the outside level, driven ones the mux value
	always_comb
	begin
		o_pin_in = i_ext;
		for (int i = 0; i < 8; i++)
			if (i_pin_oe[i])
				o_pin_in[i] = i_pin_out[i];
	end
endmodule

/* File: test/plm_lower_pin_mux_test.sv */
`timescale 1ns/100ps
module plm_lower_pin_mux_test
	import plm_pkg::*;
;
	logic        i_clk;
	logic        i_arst_n;
	logic        ce;
	logic        cyc;
	logic        stb;
	logic        we;
	logic        ack;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic [31:0] q;
	logic [9:0]  ext;
	logic [9:0]  pin_in;
	logic [7:0]  pin_out;
	logic [7:0]  pin_oe;
	logic [7:0]  gpio_out;
	logic [7:0]  gpio_in;
	logic [1:0]  hi_out;
	logic        s8;
	logic        s9;
	logic [2:0]  sck_o;
	logic [2:0]  sck_i;
	logic        conv_end;
	logic        ccb_o;
	logic        cca_o;
	logic [7:0]  per_in;
	int          n_mismatch;
	int          tests_run;

	plm_lower_pin_mux dut (
		.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(ce),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
		.i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_pin_hi_out(hi_out),
		.i_pin8_sck_sel(s8), .i_pin9_sck_sel(s9), .i_gpio_out(gpio_out), .o_gpio_in(gpio_in),
		.i_serial_ch2_clock_out(sck_o[0]), .i_serial_ch3_clock_out(sck_o[1]),
		.i_serial_ch4_clock_out(sck_o[2]), .o_serial_ch2_clock_in(sck_i[0]),
		.o_serial_ch3_clock_in(sck_i[1]), .o_serial_ch4_clock_in(sck_i[2]),
		.i_conversion_end_out(conv_end), .o_conversion_trigger_1(per_in[7]),
		.o_conversion_trigger_0(per_in[6]), .o_timer_ext_clock_b(per_in[5]),
		.o_timer_edge_input_10(per_in[4]), .i_timer_cc_ch11_b_out(ccb_o),
		.i_timer_cc_ch11_a_out(cca_o), .o_timer_cc_ch11_b_in(per_in[3]),
		.o_ext_interrupt_6_n(per_in[2]), .o_timer_cc_ch11_a_in(per_in[1]),
		.o_ext_interrupt_7_n(per_in[0])
	);

	plm_far_model far (.i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_ext(ext), .o_pin_in(pin_in));

	initial
	begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	task wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// no fixed latency assumed: the wait ends on ack or on a bound
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge i_clk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		sel  <= 4'h3;
		n = 0;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1)
			chk(32'h0, 32'h1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e);
	endtask

	task wt(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	// order: trig1 trig0 clkb edge10 cc11b ext_interrupt_6_n cc11a ext_interrupt_7_n
	function automatic logic [7:0] per(input logic [15:0] c, input logic [7:0] p);
		per = {c[10] & p[5], c[8] & p[4], c[6] & p[3], c[0] & p[0],
			(c[5:4] == 2'h1) & p[2], (c[3:2] != 2'h2) | p[1],
			(c[3:2] == 2'h1) & p[1], (c[5:4] != 2'h2) | p[2]};
	endfunction

	initial
	begin
		#(50 * 20000);
		n_mismatch++;
		wrap_up();
	end

	initial
	begin
		logic [15:0] cfg;
		logic [7:0]  p;
		n_mismatch = 0;
		tests_run = 0;
		{i_arst_n, cyc, stb, we, adr, sel, wdat, ext, gpio_out} <= '0;
		{s8, s9, sck_o, conv_end, ccb_o, cca_o} <= '0;
		ce <= 1'b1;
		wt(20);
		i_arst_n <= 1'b1;

		rd(PLM_ADR_FSEL, 32'h0);
		rd(PLM_ADR_INV, 32'h0);
		// fields only ever get codes 00, 01 and 10
		wr(PLM_ADR_FSEL, 32'haaaa);
		rd(PLM_ADR_FSEL, 32'h0028);
		wr(PLM_ADR_FSEL, 32'h5555);
		rd(PLM_ADR_FSEL, 32'h5555);
		wr(PLM_ADR_INV, 32'hffff_ffff);
		rd(PLM_ADR_INV, 32'h0380);
		rd(8'h10, 32'h0);
		$display("test registers done");

		for (int i = 0; i < 6; i++)
		begin
			cfg = (i < 2) ? 16'h0000 : ((i < 4) ? 16'h0559 : 16'h0024);
			p = i[0] ? 8'hda : 8'h25;
			wr(PLM_ADR_FSEL, {16'h0, cfg});
			ext <= {2'b00, p};
			wt(6);
			chk(per_in, per(cfg, p));
			chk(gpio_in, p);
		end
		$display("test peripheral inputs done");

		wr(PLM_ADR_FSEL, 32'h5000);
		wr(PLM_ADR_DIR, 32'h80);
		sck_o <= 3'b011;
		conv_end <= 1'b1;
		s8 <= 1'b1;
		wr(PLM_ADR_INV, 32'h0180);
		wt(4);
		chk({pin_oe[7:6], pin_out[7:6], hi_out[0]}, 5'b11010);
		wr(PLM_ADR_INV, 32'h0);
		wt(4);
		chk({pin_out[7], hi_out[0]}, 2'b11);
		wr(PLM_ADR_DIR, 32'h0);
		s9 <= 1'b1;
		wr(PLM_ADR_INV, 32'h0380);
		ext <= 10'h000;
		wt(6);
		chk({hi_out[1], sck_i, pin_oe[7]}, 5'b11110);
		wr(PLM_ADR_FSEL, 32'h0);
		wt(6);
		chk(sck_i[0], 1'b0);
		$display("test serial clocks done");

		wr(PLM_ADR_DIR, 32'hff);
		gpio_out <= 8'h5a;
		wr(PLM_ADR_INV, 32'h80);
		wt(4);
		chk({pin_oe, pin_out}, 16'hff5a);
		rd(PLM_ADR_PIN, 32'h0000005a);
		// ce low must freeze the driven pin values
		ce <= 1'b0;
		gpio_out <= 8'h00;
		wt(4);
		chk(pin_out, 8'h5a);
		ce <= 1'b1;
		wr(PLM_ADR_FSEL, 32'h0014);
		ccb_o <= 1'b1;
		cca_o <= 1'b1;
		wt(4);
		chk(pin_out, 8'h06);
		$display("test gpio outputs done");

		i_arst_n <= 1'b0;
		wt(2);
		i_arst_n <= 1'b1;
		rd(PLM_ADR_FSEL, 32'h0);
		rd(PLM_ADR_INV, 32'h0);
		rd(PLM_ADR_DIR, 32'h0);
		$display("test second reset done");
		wrap_up();
	end
endmodule
